// File: sspu_if.sv
`timescale 1ns/100ps
interface sspu_if;

	// each end drives with an active-low enable; lines resolve here
	logic mosi_dev_o;
	logic mosi_dev_oe_n;
	logic mosi_peer_o;
	logic mosi_peer_oe_n;
	logic miso_dev_o;
	logic miso_dev_oe_n;
	logic miso_peer_o;
	logic miso_peer_oe_n;
	logic sck_dev_o;
	logic sck_dev_oe_n;
	logic sck_peer_o;
	logic sck_peer_oe_n;
	logic nss_dev_o;
	logic nss_dev_oe_n;
	logic nss_peer_o;
	logic nss_peer_oe_n;
	logic mosi;
	logic miso;
	logic sck;
	logic nss;

	// undriven lines fall to pull levels: data and nss high, sck low
	assign mosi = !mosi_dev_oe_n ? mosi_dev_o : (!mosi_peer_oe_n ? mosi_peer_o : 1'b1);
	assign miso = !miso_dev_oe_n ? miso_dev_o : (!miso_peer_oe_n ? miso_peer_o : 1'b1);
	assign sck  = !sck_dev_oe_n ? sck_dev_o : (!sck_peer_oe_n ? sck_peer_o : 1'b0);
	assign nss  = !nss_dev_oe_n ? nss_dev_o : (!nss_peer_oe_n ? nss_peer_o : 1'b1);

	modport dev (
		output mosi_dev_o, mosi_dev_oe_n, miso_dev_o, miso_dev_oe_n,
		output sck_dev_o, sck_dev_oe_n, nss_dev_o, nss_dev_oe_n,
		input  mosi, miso, sck, nss
	);

	modport peer (
		output mosi_peer_o, mosi_peer_oe_n, miso_peer_o, miso_peer_oe_n,
		output sck_peer_o, sck_peer_oe_n, nss_peer_o, nss_peer_oe_n,
		input  mosi, miso, sck, nss
	);

endinterface : sspu_if

// File: sspu_peer.sv
`timescale 1ns/100ps
module sspu_peer #(
	parameter int unsigned HALF_DIV = sspu_pkg::PEER_HALF_CYC
) (
	input  wire logic        i_link_clk,
	input  wire logic        i_rst_n,
	sspu_if.peer             io,
	input  wire logic        i_master,
	input  wire logic        i_three_wire,
	input  wire logic        i_nss_level,
	input  wire logic        i_start,
	input  wire logic [7:0]  i_tx_byte,
	output logic      [7:0]  o_rx_byte,
	output logic             o_done,
	output logic             o_busy
);
	import sspu_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers on the link clock
	// ----------------------------------------------------------------
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic       sck_prev_q;

	always_ff @(posedge i_link_clk)
	begin
		if (!i_rst_n)
		begin
			pin_meta_q <= PIN_RST;
			pin_sync_q <= PIN_RST;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= {io.sck, io.mosi, io.miso, io.nss};
			pin_sync_q <= pin_meta_q;
			sck_prev_q <= pin_sync_q[3];
		end
	end

	// ----------------------------------------------------------------
	// shift engine, mode 0, msb first
	// ----------------------------------------------------------------
	logic [7:0]       shift_q;
	logic             bit_q;
	logic [2:0]       cnt_q;
	logic [DIV_W-1:0] div_q;
	logic             sck_q;
	logic             sel;
	logic             tick;
	logic             sample;
	logic             step;
	logic             done;

	// a peer slave in 3-wire use is always selected
	assign sel    = i_three_wire | ~pin_sync_q[0];
	assign tick   = (div_q == DIV_W'(HALF_DIV - 1));
	assign sample = i_master ? (o_busy & tick & ~sck_q) : (sel & pin_sync_q[3] & ~sck_prev_q);
	assign step   = i_master ? (o_busy & tick & sck_q) : (sel & ~pin_sync_q[3] & sck_prev_q);
	assign done   = step & (cnt_q == BIT_LAST);

	always_ff @(posedge i_link_clk)
	begin
		if (!i_rst_n)
		begin
			shift_q   <= BYTE_RST;
			bit_q     <= 1'b0;
			cnt_q     <= BIT_RST;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_rx_byte <= BYTE_RST;
		end
		else
		begin
			o_done <= done;
			if (sample)
				bit_q <= i_master ? pin_sync_q[1] : pin_sync_q[2];
			if (i_start && !o_busy)
			begin
				shift_q <= i_tx_byte;
				cnt_q   <= BIT_RST;
				o_busy  <= 1'b1;
			end
			else if (step)
			begin
				shift_q <= {shift_q[6:0], bit_q};
				cnt_q   <= cnt_q + 3'h1;
				if (done)
				begin
					o_busy    <= 1'b0;
					o_rx_byte <= {shift_q[6:0], bit_q};
				end
			end
		end
	end

	always_ff @(posedge i_link_clk)
	begin
		if (!i_rst_n || !i_master || !o_busy)
		begin
			div_q <= '0;
			sck_q <= 1'b0;
		end
		else if (tick)
		begin
			div_q <= '0;
			sck_q <= ~sck_q;
		end
		else
			div_q <= div_q + DIV_W'(1);
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge i_link_clk)
	begin
		if (!i_rst_n)
		begin
			io.mosi_peer_o    <= 1'b0;
			io.mosi_peer_oe_n <= 1'b1;
			io.miso_peer_o    <= 1'b0;
			io.miso_peer_oe_n <= 1'b1;
			io.sck_peer_o     <= 1'b0;
			io.sck_peer_oe_n  <= 1'b1;
			io.nss_peer_o     <= 1'b1;
			io.nss_peer_oe_n  <= 1'b1;
		end
		else
		begin
			io.mosi_peer_o    <= shift_q[7];
			io.mosi_peer_oe_n <= ~i_master;
			io.miso_peer_o    <= shift_q[7];
			io.miso_peer_oe_n <= ~(~i_master & sel);
			io.sck_peer_o     <= sck_q;
			io.sck_peer_oe_n  <= ~i_master;
			io.nss_peer_o     <= i_nss_level;
			io.nss_peer_oe_n  <= ~(i_master & ~i_three_wire);
		end
	end

endmodule // sspu_peer

// File: sspu_pkg.sv
package sspu_pkg;

	// ----------------------------------------------------------------
	// select-line modes and field layout
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_3WIRE = 2'h0;
	localparam logic [1:0] SEL_MULTI = 2'h1;

	typedef struct packed {
		logic       port_enable_bit;
		logic       master_enable_bit;
		logic [1:0] select_mode_field;
	} sspu_ctrl_s;

	localparam sspu_ctrl_s CTRL_RST = '{port_enable_bit: 1'b0, master_enable_bit: 1'b0,
		select_mode_field: SEL_MULTI};

	// ----------------------------------------------------------------
	// flag positions
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_DONE = 0;
	localparam int unsigned FLAG_WRITE_COLLISION_FLAG = 1;
	localparam int unsigned FLAG_MODE_FAULT_FLAG = 2;
	localparam int unsigned FLAG_OVRN = 3;
	localparam logic [3:0]  FLAGS_RST = 4'h0;

	// ----------------------------------------------------------------
	// counts and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [2:0] BIT_RST      = 3'h0;
	localparam logic [7:0] BYTE_RST     = 8'h00;
	localparam int unsigned DIV_W       = 8;
	localparam int unsigned SCK_HALF_CYC = 8;
	localparam int unsigned PEER_HALF_CYC = 4;
	// synchronised pins {sck, mosi, miso, nss}; nss rests high
	localparam logic [3:0] PIN_RST      = 4'h1;

endpackage : sspu_pkg

// File: sspu_port.sv
`timescale 1ns/100ps
// Behaviour
// - full duplex, master or slave, 3/4-wire
// - mosi driven as master, sampled as slave
// - bytes shift most significant bit first
// - miso input as master, output as slave
// - miso released when disabled or unselected
// - 3-wire slave always drives miso msb
// - master makes sck, slaves receive it
// - unselected 4-wire slave ignores sck
// - mode 00: 3-wire, always selected slave
// - 3-wire bus holds a single slave
// - mode 01: nss input, low selects
// - master: nss falling edge disables master
// - mode 1x: nss output follows lower bit
// - output select mode drives nss even when disabled or slave
// - nss pin routed except in 3-wire
// - mode fault clears enables, sets flag
// - transfer done flag each byte, sw clears
// - write while buffer full: ignored, collision
// - slave counts 8 edges, stores byte
module sspu_port #(
	parameter int unsigned HALF_DIV = sspu_pkg::SCK_HALF_CYC
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	sspu_if.dev                   io,
	input  wire logic             i_ctrl_wr,
	input  sspu_pkg::sspu_ctrl_s  i_ctrl_wdata,
	input  wire logic             i_data_wr,
	input  wire logic [7:0]       i_data_wdata,
	input  wire logic             i_data_rd,
	input  wire logic [3:0]       i_flag_clr,
	output sspu_pkg::sspu_ctrl_s  o_ctrl,
	output logic      [3:0]       o_flags,
	output logic      [7:0]       o_rx_data,
	output logic                  o_rx_full,
	output logic                  o_tx_full,
	output logic                  o_busy,
	output logic                  o_nss_routed
);
	import sspu_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic       sck_prev_q;
	logic       nss_prev_q;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			pin_meta_q <= PIN_RST;
			pin_sync_q <= PIN_RST;
			sck_prev_q <= 1'b0;
			nss_prev_q <= 1'b1;
		end
		else
		begin
			pin_meta_q <= {io.sck, io.mosi, io.miso, io.nss};
			pin_sync_q <= pin_meta_q;
			sck_prev_q <= pin_sync_q[3];
			nss_prev_q <= pin_sync_q[0];
		end
	end

	logic sck_s;
	logic mosi_s;
	logic miso_s;
	logic nss_s;
	assign sck_s  = pin_sync_q[3];
	assign mosi_s = pin_sync_q[2];
	assign miso_s = pin_sync_q[1];
	assign nss_s  = pin_sync_q[0];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sspu_ctrl_s        ctrl_q;
	logic [3:0]        flag_q;
	logic [7:0]        txbuf_q;
	logic              txfull_q;
	logic [7:0]        shift_q;
	logic              loaded_q;
	logic              bit_q;
	logic [2:0]        cnt_q;
	logic [7:0]        rxbuf_q;
	logic              rxfull_q;
	logic [DIV_W-1:0]  div_q;
	logic              sck_q;

	logic       en;
	logic       is_master;
	logic       is_slave;
	logic       selected;
	logic       mode_fault;
	logic       tick;
	logic       sample;
	logic       step;
	logic       byte_done;
	logic       load_shift;
	logic       write_collision_flag;
	logic       store;
	logic       overrun;
	logic [7:0] rx_byte;

	assign en        = ctrl_q.port_enable_bit;
	assign is_master = en & ctrl_q.master_enable_bit;
	assign is_slave  = en & ~ctrl_q.master_enable_bit;
	assign selected  = (ctrl_q.select_mode_field == SEL_3WIRE) |
		((ctrl_q.select_mode_field == SEL_MULTI) & ~nss_s);
	assign mode_fault = is_master & (ctrl_q.select_mode_field == SEL_MULTI) &
		nss_prev_q & ~nss_s;
	assign tick = (div_q == DIV_W'(HALF_DIV - 1));
	assign sample = (is_master & loaded_q & tick & ~sck_q) |
		(is_slave & selected & sck_s & ~sck_prev_q);
	assign step = (is_master & loaded_q & tick & sck_q) |
		(is_slave & selected & ~sck_s & sck_prev_q);
	assign byte_done  = step & (cnt_q == BIT_LAST);
	assign rx_byte    = {shift_q[6:0], bit_q};
	assign load_shift = en & txfull_q & (~loaded_q | byte_done);
	assign write_collision_flag       = i_data_wr & txfull_q;
	assign overrun    = byte_done & is_slave & rxfull_q;
	assign store      = byte_done & ~overrun;

	// ----------------------------------------------------------------
	// control bits
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			ctrl_q <= CTRL_RST;
		else if (mode_fault)
		begin
			ctrl_q.port_enable_bit   <= 1'b0;
			ctrl_q.master_enable_bit <= 1'b0;
		end
		else if (i_ctrl_wr)
			ctrl_q <= i_ctrl_wdata;
	end

	// ----------------------------------------------------------------
	// flags: a set in the clearing cycle survives
	// ----------------------------------------------------------------
	logic [3:0] flag_set;
	always_comb
	begin
		flag_set = 4'h0;
		flag_set[FLAG_DONE] = byte_done;
		flag_set[FLAG_WRITE_COLLISION_FLAG] = write_collision_flag;
		flag_set[FLAG_MODE_FAULT_FLAG] = mode_fault;
		flag_set[FLAG_OVRN] = overrun;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			flag_q <= FLAGS_RST;
		else
			flag_q <= (flag_q & ~i_flag_clr) | flag_set;
	end

	// ----------------------------------------------------------------
	// transmit buffer
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			txbuf_q  <= BYTE_RST;
			txfull_q <= 1'b0;
		end
		else if (i_data_wr & ~txfull_q)
		begin
			txbuf_q  <= i_data_wdata;
			txfull_q <= 1'b1;
		end
		else if (load_shift)
			txfull_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// shift engine, mode 0: sample on rising, shift on falling
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n || !en)
		begin
			shift_q  <= BYTE_RST;
			loaded_q <= 1'b0;
			bit_q    <= 1'b0;
			cnt_q    <= BIT_RST;
		end
		else
		begin
			if (sample)
				bit_q <= is_master ? miso_s : mosi_s;
			if (load_shift)
				shift_q <= txbuf_q;
			else if (step)
				shift_q <= rx_byte;
			if (load_shift)
				loaded_q <= 1'b1;
			else if (byte_done)
				loaded_q <= 1'b0;
			// nss fall restarts a 4-wire slave byte; 3-wire only by disable
			if (is_slave && ctrl_q.select_mode_field == SEL_MULTI && nss_prev_q && !nss_s)
				cnt_q <= BIT_RST;
			else if (step)
				cnt_q <= cnt_q + 3'h1;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n || !is_master || !loaded_q)
		begin
			div_q <= '0;
			sck_q <= 1'b0;
		end
		else if (tick)
		begin
			div_q <= '0;
			sck_q <= ~sck_q;
		end
		else
			div_q <= div_q + DIV_W'(1);
	end

	// ----------------------------------------------------------------
	// receive buffer: overrun keeps the unread byte
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			rxbuf_q  <= BYTE_RST;
			rxfull_q <= 1'b0;
		end
		else if (store)
		begin
			rxbuf_q  <= rx_byte;
			rxfull_q <= 1'b1;
		end
		else if (i_data_rd)
			rxfull_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// pins and status, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			io.mosi_dev_o    <= 1'b0;
			io.mosi_dev_oe_n <= 1'b1;
			io.miso_dev_o    <= 1'b0;
			io.miso_dev_oe_n <= 1'b1;
			io.sck_dev_o     <= 1'b0;
			io.sck_dev_oe_n  <= 1'b1;
			io.nss_dev_o     <= 1'b1;
			io.nss_dev_oe_n  <= 1'b1;
			o_nss_routed     <= 1'b1;
		end
		else
		begin
			io.mosi_dev_o    <= shift_q[7];
			io.mosi_dev_oe_n <= ~is_master;
			io.miso_dev_o    <= shift_q[7];
			io.miso_dev_oe_n <= ~(is_slave & selected);
			io.sck_dev_o     <= sck_q;
			io.sck_dev_oe_n  <= ~is_master;
			io.nss_dev_o     <= ctrl_q.select_mode_field[0];
			io.nss_dev_oe_n  <= ~ctrl_q.select_mode_field[1];
			o_nss_routed     <= (ctrl_q.select_mode_field != SEL_3WIRE);
		end
	end

	assign o_ctrl    = ctrl_q;
	assign o_flags   = flag_q;
	assign o_rx_data = rxbuf_q;
	assign o_rx_full = rxfull_q;
	assign o_tx_full = txfull_q;
	assign o_busy    = loaded_q;

endmodule // sspu_port

// File: sspu_props.sv
`timescale 1ns/100ps
module sspu_props #(
	parameter int unsigned HALF_DIV = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic mosi_dev_o,
	input wire logic mosi_dev_oe_n,
	input wire logic miso_dev_oe_n,
	input wire logic sck_dev_o,
	input wire logic sck_dev_oe_n,
	input wire logic nss_dev_oe_n,
	input wire logic nss_peer_oe_n,
	input wire logic nss
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	// length of the current sck high phase
	logic [7:0] hi_cnt_q;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n || !sck_dev_o)
			hi_cnt_q <= 8'h00;
		else
			hi_cnt_q <= hi_cnt_q + 8'h01;
	end

	reset_release_a: assert property ($rose(i_rst_n) |-> miso_dev_oe_n && mosi_dev_oe_n)
		else $error("lines driven at reset release");
	no_contention_a: assert property (!miso_dev_oe_n |-> mosi_dev_oe_n && sck_dev_oe_n)
		else $error("miso driven while acting as master");
	sck_owner_a: assert property (!sck_dev_oe_n |-> !mosi_dev_oe_n)
		else $error("sck driven without mosi");
	mosi_hold_a: assert property (
		sck_dev_o && $past(sck_dev_o) && !sck_dev_oe_n |-> $stable(mosi_dev_o))
		else $error("mosi moved while sck high");
	sck_half_a: assert property (
		$fell(sck_dev_o) && !sck_dev_oe_n |-> hi_cnt_q == 8'(HALF_DIV))
		else $error("sck high phase wrong length");
	fault_release_a: assert property (
		$fell(nss) && nss_dev_oe_n && !sck_dev_oe_n |-> ##[1:8] sck_dev_oe_n)
		else $error("master kept bus after nss fall");
	nss_out_a: assert property (!nss_dev_oe_n |-> miso_dev_oe_n)
		else $error("miso driven with nss output");
	unselect_a: assert property ($rose(nss) && !nss_peer_oe_n |-> ##[1:6] miso_dev_oe_n)
		else $error("miso kept when deselected");
endmodule // sspu_props

// File: test_sspu_port.sv
`timescale 1ns/100ps
module test_sspu_port;
	import sspu_pkg::*;
	logic sys_clk = 0, link_clk = 0, rst_n = 0;
	logic ctrl_wr = 0, data_wr = 0, data_rd = 0;
	sspu_ctrl_s ctrl_wdata = CTRL_RST;
	sspu_ctrl_s ctrl;
	logic [7:0] data_wdata = 8'h00, peer_tx = 8'h00, rx_data, p_rx, a, b;
	logic [3:0] flag_clr = 4'h0, flags;
	logic p_master = 0, p_three = 0, p_nss = 1, p_start = 0;
	logic rx_full, tx_full, busy, routed, p_done, p_busy, done_prev = 0;
	logic [7:0] dev_q[$], peer_q[$];
	logic [31:0] seed = 32'hecce;
	int miscompares = 0, n_compared = 0;

	always #12.5 sys_clk = ~sys_clk;
	always #16 link_clk = ~link_clk;

	sspu_if bus();
	// slower device sck: the peer's four-flop turnaround must fit in half a period
	sspu_port #(.HALF_DIV(12)) sspu_port_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .io(bus),
		.i_ctrl_wr(ctrl_wr), .i_ctrl_wdata(ctrl_wdata), .i_data_wr(data_wr),
		.i_data_wdata(data_wdata), .i_data_rd(data_rd), .i_flag_clr(flag_clr), .o_ctrl(ctrl),
		.o_flags(flags), .o_rx_data(rx_data), .o_rx_full(rx_full), .o_tx_full(tx_full),
		.o_busy(busy), .o_nss_routed(routed));
	sspu_peer #(.HALF_DIV(8)) sspu_peer_i (.i_link_clk(link_clk), .i_rst_n(rst_n), .io(bus),
		.i_master(p_master), .i_three_wire(p_three), .i_nss_level(p_nss), .i_start(p_start),
		.i_tx_byte(peer_tx), .o_rx_byte(p_rx), .o_done(p_done), .o_busy(p_busy));
	sspu_props #(.HALF_DIV(12)) sspu_props_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
		.mosi_dev_o(bus.mosi_dev_o), .mosi_dev_oe_n(bus.mosi_dev_oe_n),
		.miso_dev_oe_n(bus.miso_dev_oe_n), .sck_dev_o(bus.sck_dev_o),
		.sck_dev_oe_n(bus.sck_dev_oe_n), .nss_dev_oe_n(bus.nss_dev_oe_n),
		.nss_peer_oe_n(bus.nss_peer_oe_n), .nss(bus.nss));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic set_ctrl(input logic pe, input logic me, input logic [1:0] md);
		@(negedge sys_clk);
		ctrl_wr = 1;
		ctrl_wdata = '{pe, me, md};
		@(negedge sys_clk);
		ctrl_wr = 0;
		repeat (4) @(negedge sys_clk);
	endtask

	task automatic dev_write(input logic [7:0] d);
		@(negedge sys_clk);
		data_wr = 1;
		data_wdata = d;
		@(negedge sys_clk);
		data_wr = 0;
	endtask

	task automatic peer_go(input logic [7:0] d);
		@(negedge link_clk);
		p_start = 1;
		peer_tx = d;
		@(negedge link_clk);
		p_start = 0;
	endtask

	// bounded wait for the device flag (if asked) and an idle, fully checked peer
	task automatic wait_done(input logic dev, input logic rd);
		int i;
		for (i = 0; i < 4000; i++)
		begin
			@(negedge sys_clk);
			if ((!dev || flags[FLAG_DONE] === 1'b1) && p_busy === 1'b0 && peer_q.size() == 0)
				break;
		end
		if (i == 4000)
		begin
			miscompares++;
			final_report();
		end
		flag_clr = 4'h1;
		data_rd = rd;
		@(negedge sys_clk);
		flag_clr = 4'h0;
		data_rd = 0;
	endtask

	// ----------------------------------------------------------------
	// result monitors
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (flags[FLAG_DONE] === 1'b1 && !done_prev && dev_q.size() > 0)
			chk("dev rx", dev_q.pop_front(), rx_data);
		done_prev <= (flags[FLAG_DONE] === 1'b1);
	end

	always @(posedge link_clk)
		if (p_done === 1'b1 && peer_q.size() > 0)
			chk("peer rx", peer_q.pop_front(), p_rx);

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(negedge sys_clk);
		rst_n = 1;
		repeat (3) @(negedge sys_clk);
		chk("ctrl", {4'h0, CTRL_RST}, {4'h0, ctrl});
		chk("flags", 8'h00, {4'h0, flags});
		for (int m = 0; m < 4; m++)
		begin
			set_ctrl(1'b0, 1'b1, 2'(m));
			chk("routed", {7'h0, m != 0}, {7'h0, routed});
			if (m > 1)
				chk("nss out", {7'h0, m[0]}, {7'h0, bus.nss});
		end
		// device master, peer 3-wire slave
		// peer is the only slave
		p_three = 1;
		set_ctrl(1'b1, 1'b1, SEL_3WIRE);
		for (int k = 0; k < 3; k++)
		begin
			a = rnd();
			b = rnd();
			peer_go(b);
			dev_q.push_back(b);
			peer_q.push_back(a);
			dev_write(a);
			wait_done(1'b1, 1'b1);
		end
		// second byte buffered, third collides
		a = rnd();
		b = rnd();
		peer_q.push_back(a);
		peer_q.push_back(b);
		dev_write(a);
		repeat (2) @(negedge sys_clk);
		dev_write(b);
		dev_write(rnd());
		chk("write_collision_flag", 8'h01, {7'h0, flags[FLAG_WRITE_COLLISION_FLAG]});
		chk("tx full", 8'h01, {7'h0, tx_full});
		chk("busy", 8'h01, {7'h0, busy});
		wait_done(1'b1, 1'b1);
		wait_done(1'b0, 1'b1);
		// device 4-wire slave, unread byte then overrun
		set_ctrl(1'b1, 1'b0, SEL_MULTI);
		p_three = 0;
		p_master = 1;
		p_nss = 0;
		repeat (6) @(negedge sys_clk);
		chk("miso on", 8'h00, {7'h0, bus.miso_dev_oe_n});
		a = rnd();
		b = rnd();
		dev_write(a);
		dev_q.push_back(b);
		peer_q.push_back(a);
		peer_go(b);
		wait_done(1'b1, 1'b0);
		chk("rx full", 8'h01, {7'h0, rx_full});
		a = rnd();
		dev_write(a);
		dev_q.push_back(b);
		peer_q.push_back(a);
		peer_go(rnd());
		wait_done(1'b1, 1'b1);
		chk("overrun", 8'h01, {7'h0, flags[FLAG_OVRN]});
		// deselected: clocks ignored, miso released to pull-up
		p_nss = 1;
		repeat (8) @(negedge sys_clk);
		peer_q.push_back(8'hff);
		peer_go(rnd());
		wait_done(1'b0, 1'b0);
		chk("no done", 8'h00, {7'h0, flags[FLAG_DONE]});
		chk("miso unsel", 8'h01, {7'h0, bus.miso_dev_oe_n});
		set_ctrl(1'b0, 1'b0, SEL_MULTI);
		chk("miso rel", 8'h01, {7'h0, bus.miso_dev_oe_n});
		// device 3-wire slave
		p_three = 1;
		set_ctrl(1'b1, 1'b0, SEL_3WIRE);
		a = rnd();
		b = rnd();
		dev_write(a);
		dev_q.push_back(b);
		peer_q.push_back(a);
		peer_go(b);
		wait_done(1'b1, 1'b1);
		chk("miso 3w", 8'h00, {7'h0, bus.miso_dev_oe_n});
		// multi-master: nss falls under an idle master
		p_nss = 1;
		p_three = 0;
		set_ctrl(1'b1, 1'b1, SEL_MULTI);
		@(negedge link_clk);
		p_nss = 0;
		repeat (20) @(negedge sys_clk);
		chk("ctrl fault", {4'h0, 2'b00, SEL_MULTI}, {4'h0, ctrl});
		chk("mode_fault_flag", 8'h01, {7'h0, flags[FLAG_MODE_FAULT_FLAG]});
		final_report();
	end
endmodule // test_sspu_port
